// File: lasi_pkg.sv
package lasi_pkg;

   // ----------------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int COND_N = 5;
   localparam int CNT_W  = 5;

   // ----------------------------------------------------------------------
   // register offsets on the serial register port
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR   = 6'h00;
   localparam logic [ADDR_W-1:0] CHANGE_FLAGS_ADDR = 6'h01;
   localparam logic [ADDR_W-1:0] LIVE_STATE_ADDR   = 6'h02;

   // ----------------------------------------------------------------------
   // bit positions shared by enable, change and live registers
   // ----------------------------------------------------------------------
   localparam int OSC_BIT      = 4;
   localparam int LOSS_BIT     = 3;
   localparam int RECOVERY_BIT = 2;
   localparam int TX_PLL_BIT   = 1;
   localparam int OVERFLOW_BIT = 0;

   // ----------------------------------------------------------------------
   // reset values and masks
   // ----------------------------------------------------------------------
   localparam logic [DATA_W-1:0] ENABLE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] FLAGS_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] LIVE_RESET   = 8'h00;
   localparam logic [DATA_W-1:0] USED_MASK    = 8'h1F;
   localparam logic [DATA_W-1:0] UNMAPPED_RD  = 8'h00;

   // ----------------------------------------------------------------------
   // serial frame: rising clock edge numbers, counted from one
   // ----------------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_RESET       = 5'h00;
   localparam logic [CNT_W-1:0] CNT_STEP        = 5'h01;
   localparam logic [CNT_W-1:0] RW_EDGE         = 5'h01;
   localparam logic [CNT_W-1:0] ADDR_FIRST_EDGE = 5'h02;
   localparam logic [CNT_W-1:0] ADDR_LAST_EDGE  = 5'h07;
   localparam logic [CNT_W-1:0] DUMMY_EDGE      = 5'h08;
   localparam logic [CNT_W-1:0] DATA_FIRST_EDGE = 5'h09;
   localparam logic [CNT_W-1:0] DATA_LAST_EDGE  = 5'h10;

   // ----------------------------------------------------------------------
   // serial frame phases
   // ----------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      LASI_IDLE  = 2'b00,
      LASI_SHIFT = 2'b01,
      LASI_DONE  = 2'b10
   } lasi_phase_t;

   // bit index of an edge inside a field that starts at first
   function automatic logic [2:0] lasi_offset
   (
      input logic [CNT_W-1:0] edge_no,
      input logic [CNT_W-1:0] first
   );
      logic [CNT_W-1:0] diff;
      diff = edge_no - first;
      return diff[2:0];
   endfunction

   // true when edge_no lies within first..last
   function automatic logic lasi_in_field
   (
      input logic [CNT_W-1:0] edge_no,
      input logic [CNT_W-1:0] first,
      input logic [CNT_W-1:0] last
   );
      return (edge_no >= first) && (edge_no <= last);
   endfunction

endpackage

// File: lasi_serial_port.sv
`timescale 1ns/1ns

module lasi_serial_port
(
   input  wire logic                           clock_in,
   input  wire logic                           resetn_in,
   input  wire logic                           cs_n_in,
   input  wire logic                           sclk_in,
   input  wire logic                           sdi_in,
   input  wire logic [lasi_pkg::DATA_W-1:0]    rd_data_in,
   output logic      [lasi_pkg::ADDR_W-1:0]    addr_out,
   output logic      [lasi_pkg::DATA_W-1:0]    wr_data_out,
   output logic                                wr_pulse_out,
   output logic                                rd_pulse_out,
   output logic                                sdo_out,
   output logic                                sdo_oe_out
);
   import lasi_pkg::*;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   lasi_phase_t              phase_reg,  phase_next;
   logic [CNT_W-1:0]         cnt_reg,    cnt_next;
   logic                     rw_reg,     rw_next;
   logic [ADDR_W-1:0]        addr_reg,   addr_next;
   logic [DATA_W-1:0]        wdata_reg,  wdata_next;
   logic [DATA_W-1:0]        rdata_reg,  rdata_next;
   logic                     sdo_reg,    sdo_next;
   logic                     oe_reg,     oe_next;
   logic                     wr_reg,     wr_next;
   logic                     rd_reg,     rd_next;
   logic                     sclk_prev_reg;
   logic                     sclk_rise;
   logic                     sclk_fall;
   logic [CNT_W-1:0]         edge_no;

   // edges of the serial clock, sampled on the system clock
   assign sclk_rise = sclk_in & ~sclk_prev_reg;
   assign sclk_fall = ~sclk_in & sclk_prev_reg;
   assign edge_no   = cnt_reg + CNT_STEP;

   // ----------------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------------
   always_comb
   begin
      phase_next = phase_reg;
      cnt_next   = cnt_reg;
      rw_next    = rw_reg;
      addr_next  = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      sdo_next   = sdo_reg;
      oe_next    = oe_reg;
      wr_next    = 1'b0;
      rd_next    = 1'b0;
      // snapshot taken in the cycle the read request is out
      if (rd_reg)
      begin
         rdata_next = rd_data_in;
      end
      unique case (phase_reg)
         LASI_IDLE:
         begin
            oe_next = 1'b0;
            if (!cs_n_in)
            begin
               phase_next = LASI_SHIFT;
               cnt_next   = CNT_RESET;
            end
         end
         LASI_SHIFT:
         begin
            if (cs_n_in)
            begin
               phase_next = LASI_IDLE;   // short frame is dropped
               oe_next    = 1'b0;
            end
            else if (sclk_rise)
            begin
               cnt_next = edge_no;
               if (edge_no == RW_EDGE)
                  rw_next = sdi_in;
               else if (lasi_in_field(edge_no, ADDR_FIRST_EDGE,
                                      ADDR_LAST_EDGE))
                  addr_next[lasi_offset(edge_no, ADDR_FIRST_EDGE)] = sdi_in;
               else if (edge_no == DUMMY_EDGE)
                  rd_next = rw_reg;      // read request, one cycle
               else
                  wdata_next[lasi_offset(edge_no, DATA_FIRST_EDGE)] = sdi_in;
               if (edge_no == DATA_LAST_EDGE)
                  phase_next = LASI_DONE;
            end
         end
         LASI_DONE:
         begin
            if (cs_n_in)
            begin
               phase_next = LASI_IDLE;
               wr_next    = ~rw_reg;     // write lands on chip select release
               oe_next    = 1'b0;
            end
         end
      endcase
      // read data leaves lsb first on falling edges nine to sixteen
      if (phase_reg != LASI_IDLE && !cs_n_in && sclk_fall && rw_reg &&
          lasi_in_field(cnt_reg, DATA_FIRST_EDGE, DATA_LAST_EDGE))
      begin
         sdo_next = rdata_reg[lasi_offset(cnt_reg, DATA_FIRST_EDGE)];
         oe_next  = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         phase_reg     <= LASI_IDLE;
         cnt_reg       <= CNT_RESET;
         rw_reg        <= 1'b0;
         addr_reg      <= '0;
         wdata_reg     <= '0;
         rdata_reg     <= '0;
         sdo_reg       <= 1'b0;
         oe_reg        <= 1'b0;
         wr_reg        <= 1'b0;
         rd_reg        <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end
      else
      begin
         phase_reg     <= phase_next;
         cnt_reg       <= cnt_next;
         rw_reg        <= rw_next;
         addr_reg      <= addr_next;
         wdata_reg     <= wdata_next;
         rdata_reg     <= rdata_next;
         sdo_reg       <= sdo_next;
         oe_reg        <= oe_next;
         wr_reg        <= wr_next;
         rd_reg        <= rd_next;
         sclk_prev_reg <= sclk_in;
      end
   end

   // outputs straight from flip-flops
   assign addr_out     = addr_reg;
   assign wr_data_out  = wdata_reg;
   assign wr_pulse_out = wr_reg;
   assign rd_pulse_out = rd_reg;
   assign sdo_out      = sdo_reg;
   assign sdo_oe_out   = oe_reg;

endmodule // lasi_serial_port

// File: lasi_alarm_irq.sv
`timescale 1ns/1ns

// Notes on behaviour
// - oscillator lock change sets change flag bit 4.
// - loss-of-signal change sets change flag bit 3.
// - recovery lock change sets change flag bit 2.
// - transmit pll lock change sets change flag bit 1.
// - transmit buffer overflow change sets change flag bit 0.
// - a set flag raises the interrupt only when its enable at 0x00 is one.
// - oscillator flag and live bit mean nothing unless lock detect is on.
// - live bit 4 is one while the oscillator is locked.
// - live bit 3 is one while loss of signal is present.
// - live bit 2 is one while clock recovery is locked.
// - live bit 1 is one while the transmit pll is locked.
// - live bit 0 is one while transmit buffer overflow persists.
// - bits 7 to 5 of change and live registers are unused.
// - enable bit zero masks, one allows; enables reset to zero.

module lasi_alarm_irq
(
   input  wire logic   clock_in,
   input  wire logic   resetn_in,
   // serial register port
   input  wire logic   cs_n_in,
   input  wire logic   sclk_in,
   input  wire logic   sdi_in,
   output logic        sdo_out,
   output logic        sdo_oe_out,
   // monitored conditions from the analog detectors
   input  wire logic   osc_lock_detect_enable_in,
   input  wire logic   osc_locked_in,
   input  wire logic   signal_loss_in,
   input  wire logic   recovery_locked_in,
   input  wire logic   tx_pll_locked_in,
   input  wire logic   tx_buffer_overflow_in,
   // external interrupt, active high
   output logic        irq_out
);
   import lasi_pkg::*;

   // ----------------------------------------------------------------------
   // register port wiring
   // ----------------------------------------------------------------------
   logic [ADDR_W-1:0]   port_addr;
   logic [DATA_W-1:0]   port_wdata;
   logic                port_wr;
   logic                port_rd;
   logic [DATA_W-1:0]   port_rdata;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [DATA_W-1:0]   enable_reg,  enable_next;
   logic [DATA_W-1:0]   live_reg,    live_next;
   logic [DATA_W-1:0]   flags_reg,   flags_next;
   logic                irq_reg,     irq_next;

   // ----------------------------------------------------------------------
   // intermediate terms
   // ----------------------------------------------------------------------
   logic [DATA_W-1:0]   cond_vec;
   logic [DATA_W-1:0]   change_vec;
   logic [DATA_W-1:0]   clear_vec;
   logic [DATA_W-1:0]   pending_vec;
   logic                enable_write;
   logic                flags_read;

   // ----------------------------------------------------------------------
   // serial register port
   // ----------------------------------------------------------------------
   lasi_serial_port u_port
   (
      .clock_in     (clock_in),
      .resetn_in    (resetn_in),
      .cs_n_in      (cs_n_in),
      .sclk_in      (sclk_in),
      .sdi_in       (sdi_in),
      .rd_data_in   (port_rdata),
      .addr_out     (port_addr),
      .wr_data_out  (port_wdata),
      .wr_pulse_out (port_wr),
      .rd_pulse_out (port_rd),
      .sdo_out      (sdo_out),
      .sdo_oe_out   (sdo_oe_out)
   );

   // ----------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------

   // true when the port points at the given register
   function automatic logic reg_hit
   (
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] target
   );
      return addr == target;
   endfunction

   // a new event sets a flag even while it is read away
   function automatic logic flag_bit_next
   (
      input logic held,
      input logic cleared,
      input logic event_seen
   );
      return (held & ~cleared) | event_seen;
   endfunction

   // ----------------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------------

   // strobes for accesses with a side effect
   assign enable_write = port_wr && reg_hit(port_addr, IRQ_ENABLE_ADDR);
   assign flags_read   = port_rd && reg_hit(port_addr, CHANGE_FLAGS_ADDR);

   // ----------------------------------------------------------------------
   // interrupt enable register
   // ----------------------------------------------------------------------

   // only the five used bits are kept
   always_comb
   begin
      enable_next = enable_reg;
      if (enable_write)
      begin
         enable_next = port_wdata & USED_MASK;
      end
   end

   // enables come up masked
   always_ff @(posedge clock_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         enable_reg <= ENABLE_RESET;
      end
      else
      begin
         enable_reg <= enable_next;
      end
   end

   // ----------------------------------------------------------------------
   // live condition state
   // ----------------------------------------------------------------------

   // gather the detectors into register bit positions
   always_comb
   begin
      cond_vec               = LIVE_RESET;
      cond_vec[OSC_BIT]      = osc_locked_in
                               & osc_lock_detect_enable_in;
      cond_vec[LOSS_BIT]     = signal_loss_in;
      cond_vec[RECOVERY_BIT] = recovery_locked_in;
      cond_vec[TX_PLL_BIT]   = tx_pll_locked_in;
      cond_vec[OVERFLOW_BIT] = tx_buffer_overflow_in;
   end

   // live register follows the detectors
   always_comb
   begin
      live_next = cond_vec & USED_MASK;
   end

   // live state register
   always_ff @(posedge clock_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         live_reg <= LIVE_RESET;
      end
      else
      begin
         live_reg <= live_next;
      end
   end

   // ----------------------------------------------------------------------
   // change detection
   // ----------------------------------------------------------------------

   // any edge on a condition is a change event, except an oscillator edge while lock detect is off
   always_comb
   begin
      change_vec = (live_next ^ live_reg) & USED_MASK;
      // oscillator changes only count while lock detect is on
      if (!osc_lock_detect_enable_in)
      begin
         change_vec[OSC_BIT] = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // latched change flags
   // ----------------------------------------------------------------------

   // a read of the flag register clears what was handed out
   always_comb
   begin
      clear_vec = FLAGS_RESET;
      if (flags_read)
      begin
         clear_vec = flags_reg;
      end
   end

   // new events win over the clear in the same cycle
   always_comb
   begin
      // unused bits stay zero
      flags_next = FLAGS_RESET;
      flags_next[OSC_BIT] =
         flag_bit_next(flags_reg[OSC_BIT], clear_vec[OSC_BIT],
                       change_vec[OSC_BIT]);
      flags_next[LOSS_BIT] =
         flag_bit_next(flags_reg[LOSS_BIT], clear_vec[LOSS_BIT],
                       change_vec[LOSS_BIT]);
      flags_next[RECOVERY_BIT] =
         flag_bit_next(flags_reg[RECOVERY_BIT], clear_vec[RECOVERY_BIT],
                       change_vec[RECOVERY_BIT]);
      flags_next[TX_PLL_BIT] =
         flag_bit_next(flags_reg[TX_PLL_BIT], clear_vec[TX_PLL_BIT],
                       change_vec[TX_PLL_BIT]);
      flags_next[OVERFLOW_BIT] =
         flag_bit_next(flags_reg[OVERFLOW_BIT], clear_vec[OVERFLOW_BIT],
                       change_vec[OVERFLOW_BIT]);
   end

   // latched flag register
   always_ff @(posedge clock_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         flags_reg <= FLAGS_RESET;
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end

   // ----------------------------------------------------------------------
   // external interrupt
   // ----------------------------------------------------------------------

   // flags that the host lets through
   always_comb
   begin
      pending_vec = flags_reg & enable_reg;
   end

   // or of every flag qualified by its enable
   always_comb
   begin
      irq_next = |pending_vec;
   end

   // interrupt output register
   always_ff @(posedge clock_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= irq_next;
      end
   end

   // interrupt pin straight from a flip-flop
   assign irq_out = irq_reg;

   // ----------------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------------

   // unused bits and unmapped offsets read as zero
   always_comb
   begin
      unique case (port_addr)
         IRQ_ENABLE_ADDR:
         begin
            port_rdata = enable_reg;
         end
         CHANGE_FLAGS_ADDR:
         begin
            port_rdata = flags_reg;
         end
         LIVE_STATE_ADDR:
         begin
            port_rdata = live_reg;
         end
         default:
         begin
            port_rdata = UNMAPPED_RD;
         end
      endcase
   end

endmodule // lasi_alarm_irq

// File: lasi_checker.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// port checker for the alarm and interrupt block
// ----------------------------------------------------------------------
module lasi_checker
(
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   input wire logic sdo_out,
   input wire logic sdo_oe_out,
   input wire logic osc_lock_detect_enable_in,
   input wire logic osc_locked_in,
   input wire logic signal_loss_in,
   input wire logic recovery_locked_in,
   input wire logic tx_pll_locked_in,
   input wire logic tx_buffer_overflow_in,
   input wire logic irq_out
);
   logic [4:0] cond;
   logic [4:0] cond_q;
   logic [3:0] chg_hist;
   logic [7:0] cs_hist;
   logic [4:0] rise_cnt;
   logic       sclk_q;
   logic       rw_q;

   // conditions as they reach the change flags
   assign cond = {osc_locked_in & osc_lock_detect_enable_in, signal_loss_in,
                  recovery_locked_in, tx_pll_locked_in, tx_buffer_overflow_in};

   // recent history of changes, chip select and serial clock rises
   always_ff @(posedge clock_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         cond_q   <= 5'h00;
         chg_hist <= 4'h0;
         cs_hist  <= 8'hFF;
         rise_cnt <= 5'h00;
         sclk_q   <= 1'b0;
         rw_q     <= 1'b0;
      end
      else
      begin
         cond_q   <= cond;
         chg_hist <= {chg_hist[2:0], cond != cond_q};
         cs_hist  <= {cs_hist[6:0], cs_n_in};
         sclk_q   <= sclk_in;
         rise_cnt <= cs_n_in ? 5'h00 : rise_cnt + {4'h0, sclk_in & ~sclk_q};
         if (!cs_n_in && sclk_in && !sclk_q && rise_cnt == 5'h00)
            rw_q <= sdi_in;
      end
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!resetn_in);

   a_irq_has_cause: assert property ($rose(irq_out) |-> (|chg_hist) ||
      (|(cs_hist[6:0] & ~cs_hist[7:1]))) else $error("irq rose without cause");
   a_irq_drop_cause: assert property ($fell(irq_out) |-> !(&cs_hist[6:0]))
      else $error("irq fell without register access");
   a_oe_idle_low: assert property (cs_n_in && cs_hist[0] && cs_hist[1]
      |-> !sdo_oe_out) else $error("sdo enabled outside frame");
   a_oe_stays_frame: assert property (sdo_oe_out && !cs_n_in |=> sdo_oe_out)
      else $error("sdo enable dropped inside frame");
   a_oe_rise_late: assert property ($rose(sdo_oe_out)
      |-> !cs_n_in && rise_cnt >= 5'h09) else $error("sdo enabled too early");
   a_oe_read_only: assert property (sdo_oe_out |-> rw_q)
      else $error("sdo enabled in a write frame");
   a_oe_drop_cs: assert property ($fell(sdo_oe_out) |-> cs_hist[0])
      else $error("sdo enable fell with select low");
   a_sdo_steady_high: assert property (sdo_oe_out && $past(sdo_oe_out)
      && sclk_in && sclk_q |-> $stable(sdo_out)) else $error("sdo moved");

   c_irq_rise: cover property ($rose(irq_out));
   c_irq_fall: cover property ($fell(irq_out));
   c_oe_rise: cover property ($rose(sdo_oe_out));
endmodule // lasi_checker

bind lasi_alarm_irq lasi_checker u_chk
(
   .clock_in(clock_in), .resetn_in(resetn_in), .cs_n_in(cs_n_in),
   .sclk_in(sclk_in), .sdi_in(sdi_in), .sdo_out(sdo_out),
   .sdo_oe_out(sdo_oe_out), .irq_out(irq_out),
   .osc_lock_detect_enable_in(osc_lock_detect_enable_in),
   .osc_locked_in(osc_locked_in), .signal_loss_in(signal_loss_in),
   .recovery_locked_in(recovery_locked_in),
   .tx_pll_locked_in(tx_pll_locked_in),
   .tx_buffer_overflow_in(tx_buffer_overflow_in)
);

// File: lasi_host_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// host side of the serial register port
// ----------------------------------------------------------------------
module lasi_host_model
(
   input  wire logic clock_in,
   input  wire logic sdo_in,
   input  wire logic sdo_oe_in,
   output logic      cs_n_out,
   output logic      sclk_out,
   output logic      sdi_out
);
   // idle bus at time zero
   initial
   begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out  = 1'b0;
   end

   // one frame, lsb first; fewer than 16 edges aborts it
   task automatic frame(input logic rw, input logic [5:0] addr,
                        input logic [7:0] wdata, input int edges,
                        output logic [7:0] rdata);
      logic [15:0] bits;
      bits  = {wdata, ~rw, addr, rw};
      rdata = 8'h00;
      @(negedge clock_in);
      cs_n_out = 1'b0;
      for (int e = 1; e <= edges; e++)
      begin
         sdi_out = bits[e-1];
         repeat (3) @(negedge clock_in);
         if (e >= 10)
            rdata[e-10] = sdo_oe_in ? sdo_in : 1'bx; // released line
         sclk_out = 1'b1;
         repeat (3) @(negedge clock_in);
         sclk_out = 1'b0;
      end
      repeat (3) @(negedge clock_in);
      if (edges == 16)
         rdata[7] = sdo_oe_in ? sdo_in : 1'bx;
      cs_n_out = 1'b1;
      sdi_out  = ~sdi_out; // data line is meaningless between frames
      repeat (4) @(negedge clock_in);
   endtask
endmodule // lasi_host_model

// File: test_link_alarm_status_interrupts.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// self-checking bench with a reference model of flags and enables
// ----------------------------------------------------------------------
module test_link_alarm_status_interrupts;
   import lasi_pkg::*;
   logic       clock_in  = 1'b0;
   logic       resetn_in = 1'b0;
   logic       det_en, osc, loss, rec, pll, ovf;
   logic [7:0] rd;
   wire        cs_n, sclk, sdi, sdo, sdo_oe, irq;
   int         failures  = 0;
   int         tests_run = 0;
   int         exp_flags, exp_live, exp_en, seed_v;

   // 50 MHz clock
   always #10 clock_in = ~clock_in;

   lasi_alarm_irq u_dut
   (
      .clock_in(clock_in), .resetn_in(resetn_in), .cs_n_in(cs_n),
      .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
      .osc_lock_detect_enable_in(det_en), .osc_locked_in(osc),
      .signal_loss_in(loss), .recovery_locked_in(rec),
      .tx_pll_locked_in(pll), .tx_buffer_overflow_in(ovf), .irq_out(irq)
   );
   lasi_host_model u_host
   (
      .clock_in(clock_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
      .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
      u_host.frame(1'b1, a, 8'h00, 16, d);
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      u_host.frame(1'b0, a, d, 16, dummy);
      if (a == IRQ_ENABLE_ADDR)
         exp_en = d & USED_MASK;
   endtask

   // read and clear the change flags, then irq must follow
   task automatic flags_chk();
      rd_reg(CHANGE_FLAGS_ADDR, rd);
      check(rd, exp_flags[7:0]);
      exp_flags = 0;
      repeat (2) @(negedge clock_in);
      check({7'h00, irq}, {7'h00, (exp_flags & exp_en) != 0});
   endtask

   // drive {detect enable, conditions} and update the model
   task automatic set_cond(input logic [5:0] v);
      int eff;
      @(negedge clock_in);
      {det_en, osc, loss, rec, pll, ovf} = v;
      eff = v[4:0] & (v[5] ? 5'h1F : 5'h0F);
      // oscillator changes count only while lock detect is on
      exp_flags |= (eff ^ exp_live) & (v[5] ? 5'h1F : 5'h0F);
      exp_live = eff;
      repeat (4) @(negedge clock_in);
      check({7'h00, irq}, {7'h00, (exp_flags & exp_en) != 0});
   endtask

   // main sequence
   initial
   begin
      {det_en, osc, loss, rec, pll, ovf} = 6'h00;
      exp_flags = 0;
      exp_live  = 0;
      exp_en    = 0;
      seed_v    = $urandom(65291);
      repeat (10) @(negedge clock_in);
      resetn_in = 1'b1;
      repeat (3) @(negedge clock_in);
      rd_reg(IRQ_ENABLE_ADDR, rd);
      check(rd, ENABLE_RESET);
      flags_chk();
      rd_reg(6'h05, rd);
      check(rd, UNMAPPED_RD);
      wr_reg(IRQ_ENABLE_ADDR, 8'hFF);
      rd_reg(IRQ_ENABLE_ADDR, rd);
      check(rd, 8'h1F);
      wr_reg(LIVE_STATE_ADDR, 8'hFF);
      for (int b = 0; b < 5; b++)
      begin
         wr_reg(IRQ_ENABLE_ADDR, 8'h01 << b);
         set_cond(6'h20 | (6'h01 << b));
         rd_reg(LIVE_STATE_ADDR, rd);
         check(rd, exp_live[7:0]);
         flags_chk();
         set_cond(6'h20);
         rd_reg(LIVE_STATE_ADDR, rd);
         check(rd, exp_live[7:0]);
         flags_chk();
      end
      for (int i = 0; i < 12; i++)
      begin
         wr_reg(IRQ_ENABLE_ADDR, 8'($urandom));
         set_cond(6'($urandom));
         rd_reg(LIVE_STATE_ADDR, rd);
         check(rd, exp_live[7:0]);
         flags_chk();
      end
      set_cond(6'h00);
      flags_chk();
      set_cond(6'h10);
      rd_reg(LIVE_STATE_ADDR, rd);
      check(rd, exp_live[7:0]);
      flags_chk();
      set_cond(6'h30);
      flags_chk();
      wr_reg(IRQ_ENABLE_ADDR, 8'h03);
      u_host.frame(1'b0, IRQ_ENABLE_ADDR, 8'h1C, 12, rd);
      rd_reg(IRQ_ENABLE_ADDR, rd);
      check(rd, 8'h03);
      fork
         rd_reg(CHANGE_FLAGS_ADDR, rd);
         begin
            repeat (75) @(negedge clock_in);
            ovf = 1'b1;
         end
      join
      check(rd, 8'h00);
      exp_flags = 1;
      exp_live  = exp_live | 1;
      flags_chk();
      wr_reg(IRQ_ENABLE_ADDR, 8'h1F);
      @(negedge clock_in);
      resetn_in = 1'b0;
      repeat (3) @(negedge clock_in);
      check({7'h00, irq}, 8'h00);
      resetn_in = 1'b1;
      exp_en    = 0;
      exp_flags = exp_live;
      repeat (3) @(negedge clock_in);
      rd_reg(IRQ_ENABLE_ADDR, rd);
      check(rd, ENABLE_RESET);
      flags_chk();
      results();
   end

   // watchdog on a hung frame
   initial
   begin
      #400000;
      failures++;
      results();
   end
endmodule // test_link_alarm_status_interrupts
